/* include/sar_pkg.sv */
`default_nettype none
package sar_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned   SAR_FRAME_BITS   = 16;
  localparam int unsigned   SAR_LEAD_ZEROS   = 2;
  localparam int unsigned   SAR_GLITCH_FALLS = 2;
  localparam int unsigned   SAR_WAKE_FALLS   = 10;
  localparam int unsigned   SAR_CNT_W        = 5;
  localparam logic [4:0]    SAR_FALL_CNT_RST = 5'h00;
  localparam logic [15:0]   SAR_WORD_RST     = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned   SAR_CLK_PERIOD_NS = 40;
  localparam int unsigned   SAR_ACQ_NS        = 60;
  localparam int unsigned   SAR_QUIET_NS      = 4;
  localparam int unsigned   SAR_ACQ_RAW       =
    (SAR_ACQ_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
  localparam int unsigned   SAR_ACQ_CYCLES    = (SAR_ACQ_RAW < 1) ? 1 : SAR_ACQ_RAW;
  localparam int unsigned   SAR_QUIET_RAW     =
    (SAR_QUIET_NS + SAR_CLK_PERIOD_NS - 1) / SAR_CLK_PERIOD_NS;
  localparam int unsigned   SAR_QUIET_CYCLES  = (SAR_QUIET_RAW < 1) ? 1 : SAR_QUIET_RAW;
  localparam int unsigned   SAR_IDLE_W        = 4;
  localparam logic [3:0]    SAR_IDLE_RST      = 4'(SAR_ACQ_CYCLES);

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SAR_PWR_NORMAL, SAR_PWR_PARTIAL, SAR_PWR_FULL} sar_power_t;
  typedef enum logic {SAR_FRM_IDLE, SAR_FRM_ACTIVE} sar_frame_t;
  localparam sar_power_t    SAR_POWER_RST = SAR_PWR_NORMAL;

  // serial clocks needed to finish a conversion
  function automatic logic [4:0] sar_conv_falls(input int unsigned res);
    return 5'(res + SAR_LEAD_ZEROS);
  endfunction : sar_conv_falls

  // falling edges after which the next rising edge returns to track
  function automatic logic [4:0] sar_track_falls(input int unsigned res);
    return 5'(res + 1);
  endfunction : sar_track_falls

endpackage : sar_pkg
`default_nettype wire

/* rtl/sar_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  // ----------------------------------------------------------------
  // two-stage synchroniser and edge finder
  // ----------------------------------------------------------------
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
      last_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;

endmodule : sar_pin_sync
`default_nettype wire

/* rtl/sar_word_shifter.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_word_shifter (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic        shift,
  input  wire logic [15:0] word_in,
  output logic             bit_out
);

  // ----------------------------------------------------------------
  // frame word, bit 15 leaves first
  // ----------------------------------------------------------------
  logic [15:0] word_reg;
  logic [15:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (load) begin
      word_next = word_in;
    end else if (shift) begin
      word_next = {word_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      word_reg <= sar_pkg::SAR_WORD_RST;
    end else begin
      word_reg <= word_next;
    end
  end

  assign bit_out = word_reg[15];

endmodule : sar_word_shifter
`default_nettype wire

/* rtl/sar_serial_readout.sv */
// Overview of operation
// - serial clock is both conversion clock and result shift clock.
// - select falling holds the sample, starts conversion, enables data output.
// - 12-bit needs 14 clocks; track resumes on rising edge after 13th fall.
// - 12-bit select rising before 14 clocks aborts and three-states output.
// - 12-bit 16-clock frame ends with two zeros; release on 16th fall.
// - 10-bit needs 12 clocks; track resumes on rising edge after 11th fall.
// - 10-bit select rising before 12 clocks aborts and three-states output.
// - 8-bit needs 10 clocks; track resumes on rising edge after 9th fall.
// - 8-bit select rising before 10 clocks aborts and three-states output.
// - 8-bit 16-clock frame ends with six zeros; release on 16th fall.
// - first leading zero at select fall; each later fall shifts next bit.
// - final bit launched on 15th falling edge, captured on the 16th.
// - 8-bit 10-clock frame: track resumes on ninth rising edge.
// - select rising between 2nd and 10th fall aborts normal mode into partial power-down.
// - select rising before 2nd fall keeps normal mode, a glitch guard.
// - frame held past 10th fall wakes the part; next conversion is valid.
`timescale 1ns/10ps
`default_nettype none
module sar_serial_readout #(
  parameter int unsigned RESOLUTION = 12
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sclk_pin,
  input  wire logic                  cs_n_pin,
  input  wire logic [RESOLUTION-1:0] analog_code,
  output logic                       serial_result_out,
  output logic                       serial_result_out_oe,
  output logic                       track_mode,
  output var sar_pkg::sar_power_t    power_mode,
  output logic                       sample_pulse,
  output logic                       abort_pulse,
  output logic                       result_ready,
  output logic [RESOLUTION-1:0]      result_data,
  output logic                       result_valid,
  output logic                       acq_short
);

  // ----------------------------------------------------------------
  // constants of this resolution
  // ----------------------------------------------------------------
  localparam int unsigned PAD_BITS    = sar_pkg::SAR_FRAME_BITS - sar_pkg::SAR_LEAD_ZEROS
                                        - RESOLUTION;
  localparam logic [4:0]  CONV_FALLS  = sar_pkg::sar_conv_falls(RESOLUTION);
  localparam logic [4:0]  TRACK_FALLS = sar_pkg::sar_track_falls(RESOLUTION);
  localparam logic [4:0]  LAST_FALLS  = 5'(sar_pkg::SAR_FRAME_BITS);
  localparam logic [4:0]  GLITCH_FALLS = 5'(sar_pkg::SAR_GLITCH_FALLS);
  localparam logic [4:0]  WAKE_FALLS  = 5'(sar_pkg::SAR_WAKE_FALLS);
  localparam logic [3:0]  ACQ_CYCLES  = 4'(sar_pkg::SAR_ACQ_CYCLES);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_n_lvl;
  logic cs_rise;
  logic cs_fall;
  logic sclk_lvl;
  logic sclk_rise;
  logic sclk_fall;

  sar_pin_sync #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (cs_n_pin),
    .level   (cs_n_lvl),
    .rise    (cs_rise),
    .fall    (cs_fall)
  );

  sar_pin_sync #(.RESET_VAL(1'b1)) u_sclk_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (sclk_pin),
    .level   (sclk_lvl),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  sar_pkg::sar_frame_t   frame_reg, frame_next;
  sar_pkg::sar_power_t   power_reg, power_next;
  sar_pkg::sar_power_t   start_pwr_reg, start_pwr_next;
  logic [4:0]            fall_reg, fall_next;
  logic                  oe_reg, oe_next;
  logic                  track_reg, track_next;
  logic [3:0]            idle_reg, idle_next;
  logic                  acq_reg, acq_next;
  logic [RESOLUTION-1:0] code_reg, code_next;
  logic [RESOLUTION-1:0] data_reg, data_next;
  logic                  valid_reg, valid_next;
  logic                  ready_reg, ready_next;
  logic                  sample_reg, sample_next;
  logic                  abort_reg, abort_next;
  logic                  load_word;
  logic                  shift_word;
  logic [15:0]           frame_word;

  assign frame_word = {{sar_pkg::SAR_LEAD_ZEROS{1'b0}}, analog_code, {PAD_BITS{1'b0}}};

  always_comb begin
    frame_next     = frame_reg;
    power_next     = power_reg;
    start_pwr_next = start_pwr_reg;
    fall_next      = fall_reg;
    oe_next        = oe_reg;
    track_next     = track_reg;
    acq_next       = acq_reg;
    code_next      = code_reg;
    data_next      = data_reg;
    valid_next     = valid_reg;
    ready_next     = 1'b0;
    sample_next    = 1'b0;
    abort_next     = 1'b0;
    load_word      = 1'b0;
    shift_word     = 1'b0;
    idle_next      = idle_reg;
    if (frame_reg == sar_pkg::SAR_FRM_IDLE && idle_reg < ACQ_CYCLES) begin
      idle_next = idle_reg + 4'h1;
    end
    unique case (frame_reg)
      sar_pkg::SAR_FRM_IDLE: begin
        if (cs_fall) begin
          // hold the sample, start converting, drive the first zero
          frame_next     = sar_pkg::SAR_FRM_ACTIVE;
          fall_next      = sar_pkg::SAR_FALL_CNT_RST;
          oe_next        = 1'b1;
          track_next     = 1'b0;
          load_word      = 1'b1;
          code_next      = analog_code;
          sample_next    = 1'b1;
          start_pwr_next = power_reg;
          acq_next       = (idle_reg < ACQ_CYCLES);
          idle_next      = 4'h0;
        end
      end
      sar_pkg::SAR_FRM_ACTIVE: begin
        if (cs_rise) begin
          frame_next = sar_pkg::SAR_FRM_IDLE;
          oe_next    = 1'b0;
          abort_next = (fall_reg < CONV_FALLS);
          idle_next  = 4'h0;
          if (fall_reg >= WAKE_FALLS) begin
            power_next = sar_pkg::SAR_PWR_NORMAL;
          end else if (start_pwr_reg != sar_pkg::SAR_PWR_NORMAL) begin
            power_next = sar_pkg::SAR_PWR_FULL;
          end else if (fall_reg >= GLITCH_FALLS) begin
            power_next = sar_pkg::SAR_PWR_PARTIAL;
          end else begin
            power_next = sar_pkg::SAR_PWR_NORMAL;
          end
          track_next = (power_next == sar_pkg::SAR_PWR_NORMAL);
        end else begin
          if (sclk_fall && fall_reg < LAST_FALLS) begin
            // the serial clock alone advances conversion and shifting
            fall_next  = fall_reg + 5'h01;
            shift_word = 1'b1;
            if (fall_next == LAST_FALLS) begin
              oe_next = 1'b0;
            end
            if (fall_next == WAKE_FALLS) begin
              power_next = sar_pkg::SAR_PWR_NORMAL;
            end
            if (fall_next == CONV_FALLS) begin
              ready_next = 1'b1;
              data_next  = code_reg;
              valid_next = (start_pwr_reg == sar_pkg::SAR_PWR_NORMAL) && !acq_reg;
            end
          end
          if (sclk_rise && fall_reg == TRACK_FALLS) begin
            track_next = 1'b1;
          end
          if ((sclk_rise || sclk_fall) && fall_reg == sar_pkg::SAR_FALL_CNT_RST
              && start_pwr_reg == sar_pkg::SAR_PWR_PARTIAL) begin
            track_next = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_reg     <= sar_pkg::SAR_FRM_IDLE;
      power_reg     <= sar_pkg::SAR_POWER_RST;
      start_pwr_reg <= sar_pkg::SAR_POWER_RST;
      fall_reg      <= sar_pkg::SAR_FALL_CNT_RST;
      oe_reg        <= 1'b0;
      track_reg     <= 1'b1;
      idle_reg      <= sar_pkg::SAR_IDLE_RST;
      acq_reg       <= 1'b0;
      code_reg      <= '0;
      data_reg      <= '0;
      valid_reg     <= 1'b0;
      ready_reg     <= 1'b0;
      sample_reg    <= 1'b0;
      abort_reg     <= 1'b0;
    end else begin
      frame_reg     <= frame_next;
      power_reg     <= power_next;
      start_pwr_reg <= start_pwr_next;
      fall_reg      <= fall_next;
      oe_reg        <= oe_next;
      track_reg     <= track_next;
      idle_reg      <= idle_next;
      acq_reg       <= acq_next;
      code_reg      <= code_next;
      data_reg      <= data_next;
      valid_reg     <= valid_next;
      ready_reg     <= ready_next;
      sample_reg    <= sample_next;
      abort_reg     <= abort_next;
    end
  end

  sar_word_shifter u_shifter (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (load_word),
    .shift   (shift_word),
    .word_in (frame_word),
    .bit_out (serial_result_out)
  );

  assign serial_result_out_oe = oe_reg;
  assign track_mode           = track_reg;
  assign power_mode           = power_reg;
  assign sample_pulse         = sample_reg;
  assign abort_pulse          = abort_reg;
  assign result_ready         = ready_reg;
  assign result_data          = data_reg;
  assign result_valid         = valid_reg;
  assign acq_short            = acq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic start_c;
  logic run_c;
  assign start_c = (frame_reg == sar_pkg::SAR_FRM_IDLE) && cs_fall;
  assign run_c   = (frame_reg == sar_pkg::SAR_FRM_ACTIVE) && !cs_rise;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_start_frame;
    start_c |=> serial_result_out_oe && !track_mode && sample_pulse;
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("frame start wrong");

  property p_first_zero;
    start_c |=> !serial_result_out ##0 (fall_reg == 5'h00);
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first zero missing");

  property p_abort;
    (frame_reg == sar_pkg::SAR_FRM_ACTIVE) && cs_rise && fall_reg < CONV_FALLS
      |=> !serial_result_out_oe && abort_pulse;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");

  property p_release;
    run_c && sclk_fall && fall_reg == 5'h0f |=> !serial_result_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("no release on last fall");

  property p_track;
    run_c && sclk_rise && fall_reg == TRACK_FALLS |=> track_mode;
  endproperty
  a_track: assert property (p_track) else $error("track not resumed");

  property p_glitch;
    (frame_reg == sar_pkg::SAR_FRM_ACTIVE) && cs_rise && fall_reg < GLITCH_FALLS
      && start_pwr_reg == sar_pkg::SAR_PWR_NORMAL |=> power_mode == sar_pkg::SAR_PWR_NORMAL;
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch powered down");

  property p_partial;
    (frame_reg == sar_pkg::SAR_FRM_ACTIVE) && cs_rise && fall_reg >= GLITCH_FALLS
      && fall_reg < WAKE_FALLS && start_pwr_reg == sar_pkg::SAR_PWR_NORMAL
      |=> power_mode == sar_pkg::SAR_PWR_PARTIAL;
  endproperty
  a_partial: assert property (p_partial) else $error("partial power-down missed");

  property p_full;
    (frame_reg == sar_pkg::SAR_FRM_ACTIVE) && cs_rise && fall_reg < WAKE_FALLS
      && start_pwr_reg != sar_pkg::SAR_PWR_NORMAL |=> power_mode == sar_pkg::SAR_PWR_FULL;
  endproperty
  a_full: assert property (p_full) else $error("full power-down missed");

  property p_wake;
    run_c && sclk_fall && fall_reg == 5'h09 |=> power_mode == sar_pkg::SAR_PWR_NORMAL;
  endproperty
  a_wake: assert property (p_wake) else $error("wake frame failed");

  property p_msb;
    run_c && sclk_fall && fall_reg == 5'h01 |=> serial_result_out == code_reg[RESOLUTION-1];
  endproperty
  a_msb: assert property (p_msb) else $error("msb not after two zeros");

  property p_pad;
    serial_result_out_oe && fall_reg >= CONV_FALLS |-> !serial_result_out;
  endproperty
  a_pad: assert property (p_pad) else $error("padding bit not zero");

  property p_clocked_only;
    run_c && !sclk_fall && serial_result_out_oe ##1 frame_reg == sar_pkg::SAR_FRM_ACTIVE
      |-> $stable(serial_result_out);
  endproperty
  a_clocked_only: assert property (p_clocked_only) else $error("bit moved without sclk");

  c_full_frame: cover property (run_c && sclk_fall && fall_reg == 5'h0f);
  c_abort:      cover property (abort_pulse ##1 power_mode == sar_pkg::SAR_PWR_PARTIAL);
  c_full_pd:    cover property (power_mode == sar_pkg::SAR_PWR_FULL);
  c_short:      cover property (result_ready ##[1:200] cs_rise);

endmodule : sar_serial_readout
`default_nettype wire

/* testbench/sar_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sar_ctl_model (
  input  wire logic  clk,
  input  wire logic  serial_result_out,
  input  wire logic  serial_result_out_oe,
  output logic       sclk_pin,
  output logic       cs_n_pin,
  output logic       done,
  output logic       oe_ok,
  output logic [15:0] word,
  output logic [15:0] rword
);
  // ----------------------------------------------------------------
  // serial master: sclk idles high and stands still between frames
  // ----------------------------------------------------------------
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    done     = 1'b0;
    oe_ok    = 1'b0;
    word     = 16'h0000;
    rword    = 16'h0000;
  end

  // n falling edges at a 320 ns sclk period, then select rises; word holds bits read
  // on falling edges, rword bits read on rising edges; lead_low parks sclk low just
  // before select falls so that a rising edge comes ahead of the first fall
  task automatic frame(input int n, input logic lead_low);
    word  = 16'h0000;
    rword = 16'h0000;
    if (lead_low) begin
      sclk_pin = 1'b0;
      #160;
    end
    cs_n_pin = 1'b0;
    oe_ok    = 1'b1;
    if (lead_low) begin
      #160;
      rword[15] = serial_result_out;
      oe_ok     = oe_ok & serial_result_out_oe;
      sclk_pin  = 1'b1;
    end
    for (int k = 0; k < n; k++) begin
      #160;
      word[15-k] = serial_result_out;
      oe_ok      = oe_ok & serial_result_out_oe;
      sclk_pin   = 1'b0;
      #160;
      if (k < 15) begin
        rword[14-k] = serial_result_out;
        oe_ok       = oe_ok & serial_result_out_oe;
      end
      sclk_pin   = 1'b1;
    end
    #160;
    cs_n_pin = 1'b1;
    done     = 1'b1;
    #40;
    done     = 1'b0;
  endtask : frame
endmodule : sar_ctl_model
`default_nettype wire

/* testbench/sar_serial_readout_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t %s", $time, m); end end
module sar_serial_readout_tb;
  localparam int RES = 12;
  logic                clk;
  logic                reset_n;
  logic                sclk_pin;
  logic                cs_n_pin;
  logic [RES-1:0]      code;
  logic                serial_result_out;
  logic                serial_result_out_oe;
  logic                track_mode;
  sar_pkg::sar_power_t power_mode;
  logic                sample_pulse;
  logic                abort_pulse;
  logic                result_ready;
  logic [RES-1:0]      result_data;
  logic                result_valid;
  logic                acq_short;
  logic                done;
  logic                oe_ok;
  logic [15:0]         word;
  logic [15:0]         rword;
  logic [RES:0]        q_res[$];
  logic [32:0]         q_word[$];
  logic [RES:0]        exp_res;
  logic [32:0]         exp_word;
  int                  n_mismatch = 0;
  int                  tests_run = 0;
  int                  n_abort = 0;
  int                  n_sample = 0;

  always #20 clk = ~clk;

  sar_serial_readout #(.RESOLUTION(RES)) uut (
    .clk(clk), .reset_n(reset_n), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
    .analog_code(code), .serial_result_out(serial_result_out),
    .serial_result_out_oe(serial_result_out_oe), .track_mode(track_mode),
    .power_mode(power_mode), .sample_pulse(sample_pulse), .abort_pulse(abort_pulse),
    .result_ready(result_ready), .result_data(result_data),
    .result_valid(result_valid), .acq_short(acq_short)
  );

  sar_ctl_model ctl (
    .clk(clk), .serial_result_out(serial_result_out),
    .serial_result_out_oe(serial_result_out_oe), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .done(done), .oe_ok(oe_ok), .word(word), .rword(rword)
  );

  // ----------------------------------------------------------------
  // watcher: results are taken off the queues as they appear
  // ----------------------------------------------------------------
  // sampled mid-cycle so that registered outputs have settled
  always @(negedge clk) begin
    if (result_ready) begin
      exp_res = (q_res.size() != 0) ? q_res.pop_front() : 'x;
      `CHK({result_valid, result_data}, exp_res, "result")
    end
    if (done) begin
      exp_word = (q_word.size() != 0) ? q_word.pop_front() : 'x;
      `CHK({oe_ok, rword, word}, exp_word, "serial word")
    end
    if (abort_pulse)
      n_abort++;
    if (sample_pulse)
      n_sample++;
  end

  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // one frame of n falls; expected word keeps only the bits read
  // rising-edge reads see bits 1 to n, at most up to bit 15
  task automatic run(input int n, input logic valid_exp, input logic lead_low = 1'b0);
    logic [15:0] f;
    logic [15:0] w;
    logic [15:0] r;
    code = RES'($urandom);
    f = 16'({2'b00, code}) << (14 - RES);
    w = f & (16'hffff << (16 - n));
    r = f & (16'hffff << (15 - ((n > 15) ? 15 : n)));
    q_word.push_back({1'b1, r, w});
    if (n >= RES + 2)
      q_res.push_back({valid_exp, code});
    ctl.frame(n, lead_low);
    repeat (12) @(posedge clk);
    #1;
  endtask : run

  task automatic check_state(input sar_pkg::sar_power_t p, input logic trk, input string m);
    `CHK(power_mode, p, m)
    `CHK(track_mode, trk, m)
    `CHK(serial_result_out_oe, 1'b0, m)
    `CHK(acq_short, 1'b0, m)
  endtask : check_state

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk     = 1'b0;
    reset_n = 1'b0;
    code    = '0;
    void'($urandom(30279));
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "reset state");
    repeat (3) run(16, 1'b1);
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "after 16 clocks");
    run(14, 1'b1, 1'b1);
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "after 14 clocks");
    run(1, 1'b0);
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "glitch on select");
    run(2 + $urandom_range(7), 1'b0);
    check_state(sar_pkg::SAR_PWR_PARTIAL, 1'b0, "partial power-down");
    run(5, 1'b0, 1'b1);
    check_state(sar_pkg::SAR_PWR_FULL, 1'b0, "full power-down");
    run(16, 1'b0);
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "wake frame");
    run(16, 1'b1);
    run(13, 1'b0);
    check_state(sar_pkg::SAR_PWR_NORMAL, 1'b1, "abort after 13");
    `CHK(n_abort, 4, "abort count")
    `CHK(n_sample, 10, "frame count")
    `CHK(q_res.size() + q_word.size(), 0, "results missing")
    stop_test;
  end

  initial begin
    #500000;
    n_mismatch++;
    stop_test;
  end
endmodule : sar_serial_readout_tb
`default_nettype wire
